// file: rtl/tra_alarm.sv
`timescale 1ns/1ps
module tra_alarm (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// receive events and modes
	input wire tra_pkg::tra_evt_t evt_i,
	input wire tra_pkg::tra_cfg_t cfg_i,
	// register port
	input wire logic [1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_burst_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// alarm outputs
	output logic sync_loss_o,
	output logic remote_alarm_indication_o,
	output logic carrier_loss_o,
	output logic violation_pulse_out_o,
	output logic irq_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] mask;
		logic [7:0] viol;
		logic [3:0] oof_cnt;
		logic [3:0] esf_cnt;
		logic [5:0] zeros;
		logic [4:0] yel_sets;
		logic [8:0] yel_chans;
		logic [7:0] link_sh;
		logic [2:0] win_pos;
		logic [2:0] win_errs;
		logic sync_loss;
		logic remote;
		logic vpulse;
		logic [7:0] rdata;
	} tra_st_t;

	tra_st_t st_r, st_nxt;
	logic [7:0] live;
	logic fbit_err, oof, esf_evt, remote_now;
	logic oof_sat_ev, esf_sat_ev, viol_ev, viol_sat_ev;
	logic rd_single;

	// saturating 4-bit step
	function automatic logic [3:0] sat4(input logic [3:0] v, input logic inc);
		sat4 = (inc && v != tra_pkg::FRAMING_BIT_ERROR_MAX) ? v + 4'h1 : v;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		rd_single = reg_rd_i && !reg_burst_i && reg_addr_i == tra_pkg::ADDR_STATUS;
		fbit_err = cfg_i.extended_frame_mode ? evt_i.fps_err : evt_i.ft_err;
		oof = 1'b0;
		// fixed two-of-four window on tested framing bits, restarted after every fourth bit or on a declare
		if (evt_i.fbit_strobe) begin
			if (st_r.win_errs + {2'h0, fbit_err} >= tra_pkg::OOF_ERRS) begin
				oof = 1'b1;
				st_nxt.win_pos = 3'h0;
				st_nxt.win_errs = 3'h0;
			end else if (st_r.win_pos + 3'h1 >= tra_pkg::OOF_WIN) begin
				st_nxt.win_pos = 3'h0;
				st_nxt.win_errs = 3'h0;
			end else begin
				st_nxt.win_pos = st_r.win_pos + 3'h1;
				st_nxt.win_errs = st_r.win_errs + {2'h0, fbit_err};
			end
		end
		// errored superframe event depends on framing mode
		if (cfg_i.extended_frame_mode) begin
			esf_evt = oof || evt_i.crc_err;
		end else begin
			esf_evt = evt_i.fbit_strobe && (evt_i.ft_err || (cfg_i.count_fs && evt_i.fs_err));
		end
		// carrier loss zero run
		if (evt_i.bit_strobe) begin
			if (evt_i.line_bit) begin
				st_nxt.zeros = 6'h00;
			end else if (st_r.zeros != tra_pkg::CARR_ZEROS) begin
				st_nxt.zeros = st_r.zeros + 6'h01;
			end
		end
		// sync loss: auto mode follows events, manual waits for a requested resync
		if (evt_i.resync_done) begin
			st_nxt.sync_loss = 1'b0;
		end
		if (evt_i.resync_start || (!cfg_i.manual_resync && (oof || st_nxt.zeros == tra_pkg::CARR_ZEROS))) begin
			st_nxt.sync_loss = 1'b1;
		end
		// remote alarm detection
		remote_now = st_r.remote;
		if (cfg_i.extended_frame_mode) begin
			if (evt_i.link_strobe) begin
				st_nxt.link_sh = {st_r.link_sh[6:0], evt_i.link_bit};
				// a set completes on the eighth one that follows a zero
				if (evt_i.link_bit && st_r.link_sh == {1'b0, tra_pkg::LINK_ONES[6:0]}) begin
					if (st_r.yel_sets != tra_pkg::YEL_SETS) begin
						st_nxt.yel_sets = st_r.yel_sets + 5'h01;
					end
				// a run shorter than a byte breaks the pattern; judged only where the bit value flips
				end else if (evt_i.link_bit && !st_r.link_sh[0] && st_r.link_sh != tra_pkg::LINK_ZEROS) begin
					st_nxt.yel_sets = 5'h00;
				end else if (!evt_i.link_bit && st_r.link_sh[0] && st_r.link_sh != tra_pkg::LINK_ONES) begin
					st_nxt.yel_sets = 5'h00;
				end
				remote_now = st_nxt.yel_sets == tra_pkg::YEL_SETS;
			end
		end else if (cfg_i.s_bit_yellow) begin
			if (evt_i.s12_strobe) begin
				remote_now = evt_i.s12_bit;
			end
		end else if (evt_i.chan_strobe) begin
			if (evt_i.chan_bit2) begin
				st_nxt.yel_chans = 9'h000;
			end else if (st_r.yel_chans != tra_pkg::YEL_CHANS) begin
				st_nxt.yel_chans = st_r.yel_chans + 9'h001;
			end
			remote_now = st_nxt.yel_chans == tra_pkg::YEL_CHANS;
		end
		st_nxt.remote = remote_now;
		// violation pulse lasts one bit time
		if (evt_i.bit_strobe) begin
			st_nxt.vpulse = evt_i.violation && !(cfg_i.subst_enable && evt_i.subst_word);
		end
		// counters
		viol_ev = evt_i.violation && !(cfg_i.subst_enable && evt_i.subst_word);
		viol_sat_ev = viol_ev && st_r.viol == tra_pkg::VIOL_MAX;
		oof_sat_ev = oof && !st_r.sync_loss && st_r.oof_cnt == tra_pkg::FRAMING_BIT_ERROR_MAX;
		esf_sat_ev = esf_evt && !st_r.sync_loss && st_r.esf_cnt == tra_pkg::FRAMING_BIT_ERROR_MAX;
		if (viol_ev && !viol_sat_ev) begin
			st_nxt.viol = st_r.viol + 8'h01;
		end
		st_nxt.oof_cnt = sat4(st_r.oof_cnt, oof && !st_r.sync_loss);
		st_nxt.esf_cnt = sat4(st_r.esf_cnt, esf_evt && !st_r.sync_loss);
		// live conditions for the direct alarms
		live = tra_pkg::ZERO8;
		live[tra_pkg::BIT_SYNC] = st_nxt.sync_loss;
		live[tra_pkg::BIT_BLUE] = evt_i.all_ones;
		live[tra_pkg::BIT_SUBST] = evt_i.sub_seen;
		live[tra_pkg::BIT_FBIT] = evt_i.fbit_strobe && fbit_err;
		live[tra_pkg::BIT_CARR] = st_nxt.zeros == tra_pkg::CARR_ZEROS;
		live[tra_pkg::BIT_REMOTE] = remote_now;
		// single read clears direct bits whose cause is gone; burst read leaves all
		if (rd_single) begin
			st_nxt.status[5:0] = live[5:0];
		end
		st_nxt.status[5:0] = st_nxt.status[5:0] | live[5:0];
		// host writes; presets replace counts
		if (reg_wr_i) begin
			case (reg_addr_i)
				tra_pkg::ADDR_MASK: st_nxt.mask = reg_wdata_i;
				tra_pkg::ADDR_VIOL: begin
					st_nxt.viol = reg_wdata_i;
					if (reg_wdata_i != tra_pkg::VIOL_MAX) begin
						st_nxt.status[tra_pkg::BIT_VCS] = 1'b0;
					end
				end
				tra_pkg::ADDR_FRAMING_BIT_ERROR: begin
					st_nxt.esf_cnt = reg_wdata_i[7:4];
					st_nxt.oof_cnt = reg_wdata_i[3:0];
					if (reg_wdata_i != tra_pkg::VIOL_MAX) begin
						st_nxt.status[tra_pkg::BIT_ECS] = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// saturation events win over a same-cycle clear
		if (viol_sat_ev) begin
			st_nxt.status[tra_pkg::BIT_VCS] = 1'b1;
		end
		if (oof_sat_ev || esf_sat_ev) begin
			st_nxt.status[tra_pkg::BIT_ECS] = 1'b1;
		end
		// read data registered for the following cycle
		case (reg_addr_i)
			tra_pkg::ADDR_STATUS: st_nxt.rdata = st_r.status;
			tra_pkg::ADDR_MASK: st_nxt.rdata = st_r.mask;
			tra_pkg::ADDR_VIOL: st_nxt.rdata = st_r.viol;
			tra_pkg::ADDR_FRAMING_BIT_ERROR: st_nxt.rdata = {st_r.esf_cnt, st_r.oof_cnt};
			default: st_nxt.rdata = tra_pkg::ZERO8;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_r <= '0;
			st_r.sync_loss <= 1'b1; // reset forces a resync
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// mask gates combinationally so clearing a bit drops the request at once
	assign irq_o = |(st_r.status & st_r.mask);
	assign reg_rdata_o = st_r.rdata;
	assign sync_loss_o = st_r.sync_loss;
	assign remote_alarm_indication_o = st_r.remote;
	assign carrier_loss_o = st_r.zeros == tra_pkg::CARR_ZEROS;
	assign violation_pulse_out_o = st_r.vpulse;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_mask_gates_irq: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_r.mask == 8'h00) |-> !irq_o) else $error("irq with all masks clear");
	a_viol_saturates: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_r.viol == tra_pkg::VIOL_MAX && viol_ev && !reg_wr_i)
		|=> (st_r.viol == tra_pkg::VIOL_MAX && st_r.status[tra_pkg::BIT_VCS]))
		else $error("violation counter not saturated with flag");
	a_burst_keeps: assert property (@(posedge clk_i) disable iff (srst_i)
		(reg_rd_i && reg_burst_i && !reg_wr_i) |=> (st_r.status & $past(st_r.status)) == $past(st_r.status))
		else $error("burst read cleared status");
	a_framing_bit_error_hold: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_r.sync_loss && !reg_wr_i) |=> $stable(st_r.oof_cnt) && $stable(st_r.esf_cnt))
		else $error("framing counters moved during resync");
	a_vcs_sticky: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_r.status[tra_pkg::BIT_VCS] && !reg_wr_i) |=> st_r.status[tra_pkg::BIT_VCS])
		else $error("violation flag lost");
	a_manual_low: assert property (@(posedge clk_i) disable iff (srst_i)
		(cfg_i.manual_resync && !st_r.sync_loss && !evt_i.resync_start) |=> !st_r.sync_loss)
		else $error("sync loss rose without requested resync");
	a_carrier_clear: assert property (@(posedge clk_i) disable iff (srst_i)
		(evt_i.bit_strobe && evt_i.line_bit) |=> !carrier_loss_o) else $error("carrier loss held after one");
	a_vpulse_one: assert property (@(posedge clk_i) disable iff (srst_i)
		(evt_i.bit_strobe && !evt_i.violation) |=> !violation_pulse_out_o) else $error("violation pulse too long");

endmodule

// file: inc/tra_pkg.sv
package tra_pkg;

	// ----------------------------------------
	// register offsets on the configuration port
	// ----------------------------------------
	localparam logic [1:0] ADDR_STATUS = 2'h0; // receive_alarm_status
	localparam logic [1:0] ADDR_MASK = 2'h1; // alarm_interrupt_mask
	localparam logic [1:0] ADDR_VIOL = 2'h2; // line_violation_count
	localparam logic [1:0] ADDR_FRAMING_BIT_ERROR = 2'h3; // framing_error_counts

	// ----------------------------------------
	// status and mask bit positions
	// ----------------------------------------
	localparam int BIT_SYNC = 0;
	localparam int BIT_BLUE = 1;
	localparam int BIT_SUBST = 2;
	localparam int BIT_FBIT = 3;
	localparam int BIT_CARR = 4;
	localparam int BIT_REMOTE = 5;
	localparam int BIT_ECS = 6;
	localparam int BIT_VCS = 7;

	// ----------------------------------------
	// counts and reset values
	// ----------------------------------------
	localparam logic [7:0] VIOL_MAX = 8'hff;
	localparam logic [3:0] FRAMING_BIT_ERROR_MAX = 4'hf;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [5:0] CARR_ZEROS = 6'h20; // zeros that declare carrier loss
	localparam logic [4:0] YEL_SETS = 5'h10; // 00/ff pattern sets for link alarm
	localparam logic [8:0] YEL_CHANS = 9'h100; // channels with bit 2 clear
	localparam logic [7:0] LINK_ONES = 8'hff;
	localparam logic [7:0] LINK_ZEROS = 8'h00;
	localparam logic [2:0] OOF_WIN = 3'h4; // framing bits in the out-of-frame window
	localparam logic [2:0] OOF_ERRS = 3'h2; // errors in window that declare it

	// ----------------------------------------
	// event carrier from synchronizer and decoder
	// ----------------------------------------
	typedef struct packed {
		logic line_bit; // received bit is a one
		logic bit_strobe; // one bit time
		logic violation; // violation on this bit
		logic subst_word; // violation belongs to a substitution word
		logic sub_seen; // substitution code word seen
		logic fbit_strobe; // framing bit tested this bit
		logic ft_err; // terminal framing bit wrong
		logic fs_err; // signaling framing bit wrong
		logic fps_err; // pattern sequence bit wrong
		logic crc_err; // checksum error, one per superframe
		logic link_strobe; // facility link bit valid
		logic link_bit;
		logic chan_strobe; // channel boundary
		logic chan_bit2; // bit 2 of channel
		logic s12_strobe; // frame 12 signaling bit valid
		logic s12_bit;
		logic all_ones; // all-ones alarm condition
		logic resync_done; // synchronizer found frame
		logic resync_start; // host or reset requested resync
	} tra_evt_t;

	// ----------------------------------------
	// mode settings
	// ----------------------------------------
	typedef struct packed {
		logic extended_frame_mode; // 24-frame mode when high
		logic subst_enable; // substitution coding enabled
		logic s_bit_yellow; // twelve-frame alarm by frame 12 bit
		logic manual_resync; // auto resync disabled
		logic count_fs; // twelve-frame errored-superframe count takes signaling bits too
	} tra_cfg_t;

endpackage

// file: tb/tra_evt_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// receive synchronizer and decoder stand-in
// ----------------------------------------
module tra_evt_src (
	// clock
	input wire logic clk_i,
	// event carrier toward the alarm block
	output tra_pkg::tra_evt_t evt_o
);
	// idle line carries ones so no zero run builds up between events
	localparam tra_pkg::tra_evt_t IDLE = 19'h40000;

	initial begin
		evt_o = IDLE;
	end

	// one-cycle event, driven off the sampling edge
	task automatic send(input tra_pkg::tra_evt_t e);
		@(negedge clk_i);
		evt_o = e | IDLE;
		@(negedge clk_i);
		evt_o = IDLE;
	endtask

	// run of received bits, one per cycle
	task automatic bits(input int n, input logic v);
		tra_pkg::tra_evt_t t;
		t = IDLE;
		t.bit_strobe = 1'b1;
		t.line_bit = v;
		repeat (n) begin
			@(negedge clk_i);
			evt_o = t;
		end
		@(negedge clk_i);
		evt_o = IDLE;
	endtask

	// eight facility link bits of one value
	task automatic link_byte(input logic v);
		tra_pkg::tra_evt_t t;
		t = IDLE;
		t.link_strobe = 1'b1;
		t.link_bit = v;
		repeat (8) begin
			@(negedge clk_i);
			evt_o = t;
		end
		@(negedge clk_i);
		evt_o = IDLE;
	endtask
endmodule

// file: tb/tb_tra_alarm.sv
`timescale 1ns/1ps
module tb_tra_alarm;
	logic clk_i, srst_i, reg_wr_i, reg_rd_i, reg_burst_i;
	logic [1:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o;
	logic sync_loss_o, remote_alarm_indication_o, carrier_loss_o, violation_pulse_out_o, irq_o;
	tra_pkg::tra_cfg_t cfg_i;
	tra_pkg::tra_evt_t evt_i, e;
	int errors, compares, cycles;

	tra_evt_src src (.clk_i(clk_i), .evt_o(evt_i));
	tra_alarm uut (.clk_i(clk_i), .srst_i(srst_i), .evt_i(evt_i), .cfg_i(cfg_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_burst_i(reg_burst_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .sync_loss_o(sync_loss_o), .remote_alarm_indication_o(remote_alarm_indication_o),
		.carrier_loss_o(carrier_loss_o), .violation_pulse_out_o(violation_pulse_out_o), .irq_o(irq_o));

	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// the whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors = errors + 1;
			final_report();
		end
	end

	// ----------------------------------------
	// compares and register port tasks
	// ----------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		compares = compares + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] dv);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_wdata_i = dv;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask
	// read data stands the cycle after the taking edge
	task automatic rd(input logic [1:0] a, input logic b, input logic [7:0] exp);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_burst_i = b;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		reg_burst_i = 1'b0;
		chk8(reg_rdata_o, exp);
	endtask
	task automatic final_report();
		if (errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		errors = 0;
		compares = 0;
		cycles = 0;
		srst_i = 1'b1;
		{reg_wr_i, reg_rd_i, reg_burst_i, reg_addr_i, reg_wdata_i} = '0;
		cfg_i = '0;
		cfg_i.extended_frame_mode = 1'b1;
		cfg_i.subst_enable = 1'b1;
		repeat (5) @(posedge clk_i);
		@(negedge clk_i);
		srst_i = 1'b0;
		// reset forces a resync, latched in status while it lasts
		chk1(sync_loss_o, 1'b1);
		rd(tra_pkg::ADDR_MASK, 1'b0, 8'h00);
		rd(tra_pkg::ADDR_STATUS, 1'b0, 8'h01);
		e = '0;
		e.resync_done = 1'b1;
		src.send(e);
		chk1(sync_loss_o, 1'b0);
		rd(tra_pkg::ADDR_STATUS, 1'b0, 8'h01);
		rd(tra_pkg::ADDR_STATUS, 1'b0, 8'h00);
		// mask, request line, burst versus single read
		wr(tra_pkg::ADDR_MASK, 8'hff);
		rd(tra_pkg::ADDR_MASK, 1'b0, 8'hff);
		e = '0;
		e.sub_seen = 1'b1;
		src.send(e);
		chk1(irq_o, 1'b1);
		wr(tra_pkg::ADDR_MASK, 8'hfb);
		chk1(irq_o, 1'b0);
		wr(tra_pkg::ADDR_MASK, 8'hff);
		chk1(irq_o, 1'b1);
		rd(tra_pkg::ADDR_STATUS, 1'b1, 8'h04);
		chk1(irq_o, 1'b1);
		rd(tra_pkg::ADDR_STATUS, 1'b0, 8'h04);
		rd(tra_pkg::ADDR_STATUS, 1'b0, 8'h00);
		chk1(irq_o, 1'b0);
		// violation counter: substitution skip, saturation, flag clearing
		wr(tra_pkg::ADDR_VIOL, 8'hfe);
		e = '0;
		e.violation = 1'b1;
		e.subst_word = 1'b1;
		src.send(e);
		rd(tra_pkg::ADDR_VIOL, 1'b0, 8'hfe);
		e.subst_word = 1'b0;
		src.send(e);
		rd(tra_pkg::ADDR_VIOL, 1'b0, 8'hff);
		chk1(irq_o, 1'b0);
		src.send(e);
		rd(tra_pkg::ADDR_VIOL, 1'b0, 8'hff);
		chk1(irq_o, 1'b1);
		rd(tra_pkg::ADDR_STATUS, 1'b0, 8'h80);
		rd(tra_pkg::ADDR_STATUS, 1'b0, 8'h80);
		wr(tra_pkg::ADDR_VIOL, 8'hff);
		rd(tra_pkg::ADDR_STATUS, 1'b0, 8'h80);
		wr(tra_pkg::ADDR_VIOL, 8'h00);
		rd(tra_pkg::ADDR_STATUS, 1'b0, 8'h00);
		// framing counters, extended mode
		wr(tra_pkg::ADDR_FRAMING_BIT_ERROR, 8'hef);
		e = '0;
		e.crc_err = 1'b1;
		src.send(e);
		rd(tra_pkg::ADDR_FRAMING_BIT_ERROR, 1'b0, 8'hff);
		src.send(e);
		rd(tra_pkg::ADDR_STATUS, 1'b0, 8'h40);
		wr(tra_pkg::ADDR_FRAMING_BIT_ERROR, 8'h00);
		rd(tra_pkg::ADDR_STATUS, 1'b0, 8'h00);
		e = '0;
		e.fbit_strobe = 1'b1;
		e.fps_err = 1'b1;
		src.send(e);
		rd(tra_pkg::ADDR_FRAMING_BIT_ERROR, 1'b0, 8'h00);
		src.send(e);
		chk1(sync_loss_o, 1'b1);
		rd(tra_pkg::ADDR_FRAMING_BIT_ERROR, 1'b0, 8'h11);
		e = '0;
		e.crc_err = 1'b1;
		src.send(e);
		rd(tra_pkg::ADDR_FRAMING_BIT_ERROR, 1'b0, 8'h11);
		e = '0;
		e.resync_done = 1'b1;
		src.send(e);
		// twelve-frame mode: signaling bit errors only when selected
		cfg_i.extended_frame_mode = 1'b0;
		e = '0;
		e.fbit_strobe = 1'b1;
		e.fs_err = 1'b1;
		src.send(e);
		rd(tra_pkg::ADDR_FRAMING_BIT_ERROR, 1'b0, 8'h11);
		cfg_i.count_fs = 1'b1;
		src.send(e);
		rd(tra_pkg::ADDR_FRAMING_BIT_ERROR, 1'b0, 8'h21);
		// carrier loss on the 32nd zero, dropped by the next one
		src.bits(31, 1'b0);
		chk1(carrier_loss_o, 1'b0);
		src.bits(1, 1'b0);
		chk1(carrier_loss_o, 1'b1);
		chk1(sync_loss_o, 1'b1);
		src.bits(1, 1'b1);
		chk1(carrier_loss_o, 1'b0);
		// manual resync: carrier loss must not raise sync loss
		e = '0;
		e.resync_done = 1'b1;
		src.send(e);
		cfg_i.manual_resync = 1'b1;
		src.bits(32, 1'b0);
		chk1(carrier_loss_o, 1'b1);
		chk1(sync_loss_o, 1'b0);
		src.bits(1, 1'b1);
		cfg_i.manual_resync = 1'b0;
		// violation pulse stands one bit time
		e = '0;
		e.bit_strobe = 1'b1;
		e.violation = 1'b1;
		src.send(e);
		chk1(violation_pulse_out_o, 1'b1);
		src.bits(1, 1'b1);
		chk1(violation_pulse_out_o, 1'b0);
		// link alarm after sixteen 00/ff sets
		cfg_i.extended_frame_mode = 1'b1;
		repeat (15) begin
			src.link_byte(1'b0);
			src.link_byte(1'b1);
		end
		chk1(remote_alarm_indication_o, 1'b0);
		src.link_byte(1'b0);
		src.link_byte(1'b1);
		chk1(remote_alarm_indication_o, 1'b1);
		final_report();
	end
endmodule
